//--- hdl/sadc_ctrl.sv
// Purpose: Readout and conversion sequencing of a serial-output 8-bit converter
// Assumes: Select and shift clock are asynchronous pins; comparator result is
//          supplied as an 8-bit code with over/under range flags
// Notes: Results pass through a 4-word FIFO; conversion stalls when it is full
`timescale 1ns/1ps
module sadc_ctrl (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_sel_n,
    input wire logic i_shift_clk,
    input wire logic [7:0] i_code,
    input wire logic i_over,
    input wire logic i_under,
    output logic o_dout,
    output logic o_dout_oe,
    output logic o_track,
    output logic o_hold,
    output logic o_busy,
    output logic [7:0] o_res_data,
    output logic o_res_valid,
    input wire logic i_res_ready
);
    // Pin synchronisers; first stages read only by second stages
    logic sel_m_q, sel_s_q;
    logic sck_m_q, sck_s_q, sck_p_q;
    logic sel_f_q, sel_f_d;
    logic [1:0] rise_cnt_q, rise_cnt_d;
    logic sel_act_q, sel_act_d;
    logic sel_fall_ev, sck_fall_ev;
    sadc_pkg::sadc_state_e st_q, st_d;
    logic [3:0] edge_cnt_q, edge_cnt_d;
    logic [5:0] cyc_q, cyc_d;
    logic [7:0] result_q, result_d;
    logic [7:0] shreg_q, shreg_d;
    logic dout_q, dout_d, oe_q, oe_d;
    logic track_q, hold_q, busy_q;
    logic [7:0] conv_code;
    logic f_wready, f_push;

    function automatic logic [7:0] clamp_code(input logic [7:0] c, input logic ov,
                                              input logic un);
        if (ov) begin
            clamp_code = sadc_pkg::RESULT_FULL;
        end else if (un) begin
            clamp_code = sadc_pkg::RESULT_ZERO;
        end else begin
            clamp_code = c;
        end
    endfunction

    // Two-flop crossing of both pins, plus a delayed shift clock copy for edges
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            sel_m_q <= 1'b1;
            sel_s_q <= 1'b1;
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
            sck_p_q <= 1'b0;
        end else begin
            sel_m_q <= i_sel_n;
            sel_s_q <= sel_m_q;
            sck_m_q <= i_shift_clk;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
        end
    end

    // Noise filter: a low select must survive two rising edges, then the
    // falling half-cycle, modelled as one more full cycle before acceptance
    always_comb begin
        sel_f_d = sel_f_q;
        rise_cnt_d = rise_cnt_q;
        sel_act_d = 1'b0;
        if (sel_s_q) begin
            rise_cnt_d = 2'h0;
            sel_f_d = 1'b1;
        end else if (sel_f_q) begin
            if (rise_cnt_q == 2'h2) begin
                sel_f_d = 1'b0;
                sel_act_d = 1'b1;
            end else begin
                rise_cnt_d = rise_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            sel_f_q <= 1'b1;
            rise_cnt_q <= 2'h0;
            sel_act_q <= 1'b0;
        end else begin
            sel_f_q <= sel_f_d;
            rise_cnt_q <= rise_cnt_d;
            sel_act_q <= sel_act_d;
        end
    end

    assign sel_fall_ev = sel_act_q;
    // Shift edges count only while filtered select is low and pin still low
    assign sck_fall_ev = !sel_f_q && !sel_s_q && sck_p_q && !sck_s_q;
    assign conv_code = clamp_code(i_code, i_over, i_under);
    assign f_push = busy_q && !sel_fall_ev && (st_q == sadc_pkg::SADC_CONV)
                    && (cyc_q == sadc_pkg::TOTAL_CYCLES - 6'h01);

    // Sequencer: frame counting, sample, hold and conversion on the
    // internal clock only; the shift clock is merely an edge input
    always_comb begin
        st_d = st_q;
        edge_cnt_d = edge_cnt_q;
        cyc_d = cyc_q;
        result_d = result_q;
        shreg_d = shreg_q;
        dout_d = dout_q;
        oe_d = !sel_s_q && !sel_f_q;
        if (sel_s_q) begin
            dout_d = 1'b0;
        end
        if (sel_fall_ev) begin
            // Recognised select fall aborts any conversion in flight
            st_d = sadc_pkg::SADC_IDLE;
            edge_cnt_d = 4'h0;
            cyc_d = 6'h00;
            shreg_d = result_q;
            dout_d = result_q[7];
        end else if (sck_fall_ev && edge_cnt_q != sadc_pkg::EDGES_PER_FRAME) begin
            edge_cnt_d = edge_cnt_q + 4'h1;
            shreg_d = {shreg_q[6:0], 1'b0};
            dout_d = shreg_q[6];
            if (edge_cnt_q == sadc_pkg::SAMPLE_EDGE - 4'h1) begin
                st_d = sadc_pkg::SADC_TRACK;
            end
            if (edge_cnt_q == sadc_pkg::EDGES_PER_FRAME - 4'h1) begin
                st_d = sadc_pkg::SADC_HOLD;
                cyc_d = 6'h00;
            end
        end else begin
            case (st_q)
                sadc_pkg::SADC_HOLD: begin
                    cyc_d = cyc_q + 6'h01;
                    if (cyc_q == sadc_pkg::HOLD_CYCLES - 6'h01) begin
                        st_d = sadc_pkg::SADC_CONV;
                    end
                end
                sadc_pkg::SADC_CONV: begin
                    // A full FIFO stalls the last cycle rather than drop data
                    if (cyc_q != sadc_pkg::TOTAL_CYCLES - 6'h01) begin
                        cyc_d = cyc_q + 6'h01;
                    end else if (f_wready) begin
                        result_d = conv_code;
                        // Select may stay low across conversions: the next
                        // frame must start from the new result's MSB
                        shreg_d = conv_code;
                        dout_d = sel_s_q ? 1'b0 : conv_code[7];
                        st_d = sadc_pkg::SADC_IDLE;
                        edge_cnt_d = 4'h0;
                        cyc_d = 6'h00;
                    end
                end
                default: begin
                    cyc_d = cyc_q;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st_q <= sadc_pkg::SADC_IDLE;
            edge_cnt_q <= 4'h0;
            cyc_q <= 6'h00;
            result_q <= sadc_pkg::RESULT_RESET;
            shreg_q <= sadc_pkg::RESULT_RESET;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            track_q <= 1'b0;
            hold_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            edge_cnt_q <= edge_cnt_d;
            cyc_q <= cyc_d;
            result_q <= result_d;
            shreg_q <= shreg_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            track_q <= (st_d == sadc_pkg::SADC_TRACK);
            hold_q <= (st_d == sadc_pkg::SADC_HOLD) || (st_d == sadc_pkg::SADC_CONV);
            busy_q <= (st_d == sadc_pkg::SADC_HOLD) || (st_d == sadc_pkg::SADC_CONV);
        end
    end

    // Result queue; the consumer may stall and so hold conversion at its end
    sadc_fifo #(
        .WIDTH(sadc_pkg::RES_W),
        .DEPTH(sadc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_wdata(conv_code),
        .i_wvalid(f_push),
        .o_wready(f_wready),
        .o_rdata(o_res_data),
        .o_rvalid(o_res_valid),
        .i_rready(i_res_ready)
    );

    assign o_dout = dout_q;
    assign o_dout_oe = oe_q;
    assign o_track = track_q;
    assign o_hold = hold_q;
    assign o_busy = busy_q;

    property p_oe_off_when_high;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        sel_s_q |=> !o_dout_oe;
    endproperty
    a_oe_off_when_high: assert property (p_oe_off_when_high)
        else $error("data output enabled while select high");

    property p_filter_delay;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        $fell(sel_s_q) ##1 !sel_s_q [*2] |-> ##1 sel_act_q;
    endproperty
    a_filter_delay: assert property (p_filter_delay)
        else $error("select fall not recognised after filter");

    property p_no_early_act;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        $fell(sel_s_q) |-> !sel_act_q [*3];
    endproperty
    a_no_early_act: assert property (p_no_early_act)
        else $error("select fall acted on too early");

    property p_msb_first;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        sel_act_q |=> (o_dout == $past(result_q[7]));
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("MSB not driven at select fall");

    property p_track_after4;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (sck_fall_ev && edge_cnt_q == 4'h3 && !sel_fall_ev) |=> o_track;
    endproperty
    a_track_after4: assert property (p_track_after4)
        else $error("sampling not started after fourth edge");

    property p_hold_len;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (st_q == sadc_pkg::SADC_HOLD && cyc_q == 6'h00 && !sel_fall_ev)
            |-> (st_q == sadc_pkg::SADC_HOLD) [*4] ##1 (st_q == sadc_pkg::SADC_CONV)
            or ##[0:3] sel_fall_ev or ##[0:3] sck_fall_ev;
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("hold phase not four cycles");

    property p_abort;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        sel_fall_ev |=> (st_q == sadc_pkg::SADC_IDLE) && (edge_cnt_q == 4'h0);
    endproperty
    a_abort: assert property (p_abort)
        else $error("recognised select fall did not abort");

    property p_clamp;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (f_push && f_wready && i_over) |=> (result_q == sadc_pkg::RESULT_FULL);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("over range result not all ones");

    property p_clamp_low;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (f_push && f_wready && i_under && !i_over) |=> (result_q == sadc_pkg::RESULT_ZERO);
    endproperty
    a_clamp_low: assert property (p_clamp_low)
        else $error("under range result not all zeros");

    property p_extra_edges;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (sck_fall_ev && edge_cnt_q == sadc_pkg::EDGES_PER_FRAME)
            |=> (edge_cnt_q == sadc_pkg::EDGES_PER_FRAME) || (edge_cnt_q == 4'h0);
    endproperty
    a_extra_edges: assert property (p_extra_edges)
        else $error("shift edge beyond the eighth was counted");

    property p_first_shift;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (sck_fall_ev && !sel_fall_ev && edge_cnt_q == 4'h0)
            |=> (o_dout == $past(result_q[6]));
    endproperty
    a_first_shift: assert property (p_first_shift)
        else $error("first shift edge did not present the second bit");
endmodule // sadc_ctrl

//--- hdl/sadc_fifo.sv
// Purpose: Small flop-based FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes: Full and empty are exact; one-slot pointers wrap by index
`timescale 1ns/1ps
module sadc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [WIDTH-1:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_rready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Pointer and storage update; a pop frees a slot only from the next cycle
    always_comb begin
        push = i_wvalid && o_wready;
        pop = o_rvalid && i_rready;
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = i_wdata;
            wp_d = nxt(wp_q);
        end
        if (pop) begin
            rp_d = nxt(rp_q);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

    // Flags straight from the count
    assign o_wready = (cnt_q != (AW+1)'(DEPTH));
    assign o_rvalid = (cnt_q != '0);
    assign o_rdata = mem_q[rp_q];
endmodule // sadc_fifo

//--- hdl/sadc_pkg.sv
// Purpose: Shared constants for the serial converter readout control
// Assumes: Internal clock of 10 MHz (100 ns period)
// Notes: Only CONV_MAX_CYC derives from a time; the other counts are fixed cycle numbers
package sadc_pkg;
    localparam int RES_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] EDGES_PER_FRAME = 4'h8;
    localparam logic [3:0] SAMPLE_EDGE = 4'h4;
    localparam logic [5:0] HOLD_CYCLES = 6'h04;
    localparam logic [5:0] CONV_CYCLES = 6'h20;
    localparam logic [5:0] TOTAL_CYCLES = 6'h24;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_MAX_US = 17;
    localparam int CONV_MAX_CYC = (CONV_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int CYCLE_FAST_US = 22;
    localparam int CYCLE_SLOW_US = 25;
    localparam logic [RES_W-1:0] RESULT_RESET = 8'h00;
    localparam logic [RES_W-1:0] RESULT_FULL = 8'hFF;
    localparam logic [RES_W-1:0] RESULT_ZERO = 8'h00;
    typedef enum logic [3:0] {
        SADC_IDLE = 4'b0001,
        SADC_TRACK = 4'b0010,
        SADC_HOLD = 4'b0100,
        SADC_CONV = 4'b1000
    } sadc_state_e;
endpackage

//--- test/sadc_host_model.sv
// Purpose: Behavioural controller driving select and the shift clock
// Assumes: Shift clock parked low outside frames, 800 ns period
// Notes: Own delays, so edges land at no fixed phase of the internal clock
`timescale 1ns/1ps
module sadc_host_model (
    input wire logic i_dout,
    input wire logic i_dout_oe,
    input wire logic i_track,
    output logic o_sel_n,
    output logic o_shift_clk
);
    // Deselected and parked from time zero
    initial begin
        o_sel_n = 1'b1;
        o_shift_clk = 1'b0;
    end

    // Select, settle, then n cycles; pins sampled just before each fall
    task automatic frame(input int n, output logic [7:0] bits, output logic [7:0] trk,
                         output logic oe_ok);
        oe_ok = 1'b1;
        #37 o_sel_n = 1'b0; // Phase unrelated to the internal clock
        #1000;
        for (int k = 0; k < n; k++) begin
            o_shift_clk = 1'b1;
            #400;
            if (k < 8) begin
                bits[7-k] = i_dout;
                trk[7-k] = i_track;
            end
            oe_ok &= (i_dout_oe === 1'b1);
            o_shift_clk = 1'b0; // One clean edge per cycle
            if (k < n - 1) #400;
        end
    endtask

    // Caller keeps select low until the conversion is over, except in the abort test
    task automatic release_sel();
        o_sel_n = 1'b1;
    endtask

    // Shift activity while deselected, which the device must ignore
    task automatic stray(input int n);
        for (int k = 0; k < n; k++) begin
            #400 o_shift_clk = 1'b1;
            #400 o_shift_clk = 1'b0;
        end
    endtask
endmodule // sadc_host_model

//--- test/serial_adc_readout_control_tb_top.sv
// Purpose: Self-checking bench for the serial converter readout control
// Assumes: 10 MHz internal clock, 800 ns shift clock from the host model
// Notes: Results are taken one word at a time so FIFO fill is controlled
`timescale 1ns/1ps
module serial_adc_readout_control_tb_top;
    logic sys_clk, resetn, sel_n, shift_clk, over, under, res_ready;
    logic dout, dout_oe, track, hold, busy, res_valid;
    logic [7:0] code, res_data;
    int failures = 0;
    int compares = 0;
    int hold_run = 0;

    sadc_ctrl i_dut (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_sel_n(sel_n),
        .i_shift_clk(shift_clk), .i_code(code), .i_over(over), .i_under(under),
        .o_dout(dout), .o_dout_oe(dout_oe), .o_track(track), .o_hold(hold),
        .o_busy(busy), .o_res_data(res_data), .o_res_valid(res_valid),
        .i_res_ready(res_ready));
    sadc_host_model i_host (.i_dout(dout), .i_dout_oe(dout_oe), .i_track(track),
        .o_sel_n(sel_n), .o_shift_clk(shift_clk));

    // Internal clock, 100 ns
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Hold length counted on the clock itself, so a frame longer than eight
    // edges, which returns late, still sees the whole hold and conversion
    always @(posedge sys_clk) begin
        if (hold === 1'b1) begin
            hold_run <= hold_run + 1;
        end else begin
            hold_run <= 0;
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bounded wait for hold, then its length in cycles, capped at lim
    task automatic wait_hold(input int lim, output int len);
        for (int i = 0; i < 12 && hold !== 1'b1; i++) @(negedge sys_clk);
        check("hold_start", 8'h03, {track, hold, busy});
        while (hold === 1'b1 && hold_run < lim) @(negedge sys_clk);
        len = hold_run;
    endtask

    // Take one word with a single ready cycle; ready stays low otherwise
    task automatic get_word(input logic [7:0] exp);
        for (int i = 0; i < 80 && res_valid !== 1'b1; i++) @(negedge sys_clk);
        check("word", exp, res_data);
        @(posedge sys_clk);
        res_ready <= 1'b1;
        @(posedge sys_clk);
        res_ready <= 1'b0;
        @(negedge sys_clk);
    endtask

    // One frame: next code in, previous result out, tracking window seen
    task automatic run_frame(input int n, input logic [7:0] nxt, input logic o,
                             input logic u, input logic [7:0] prev, input int lim,
                             output int len);
        logic [7:0] bits, trk;
        logic ok;
        @(posedge sys_clk);
        code <= nxt;
        over <= o;
        under <= u;
        i_host.frame(n, bits, trk, ok);
        check("oe", 8'h01, ok);
        check("bits", prev, bits);
        check("track", 8'h0F, trk);
        wait_hold(lim, len);
    endtask

    task automatic t_convert(input int n, input logic [7:0] nxt, input logic o,
                             input logic u, input logic [7:0] prev,
                             input logic [7:0] res, input logic take);
        int len;
        run_frame(n, nxt, o, u, prev, 200, len);
        check("conv_len", {2'h0, sadc_pkg::TOTAL_CYCLES}, len[7:0]);
        check("conv_max", 8'h01, len <= sadc_pkg::CONV_MAX_CYC);
        i_host.release_sel();
        repeat (5) @(negedge sys_clk);
        check("oe_off", 8'h00, dout_oe);
        if (take) get_word(res);
    endtask

    task automatic t_idle();
        i_host.stray(4);
        check("idle", 8'h00, {dout_oe, track, hold, busy, res_valid});
    endtask

    // Select dropped again in mid-conversion: no word may appear
    task automatic t_abort();
        int len;
        logic [7:0] b, t;
        logic k, seen;
        run_frame(8, 8'h77, 1'b0, 1'b0, 8'h5A, 0, len);
        repeat (4) @(negedge sys_clk);
        i_host.release_sel();
        #800;
        i_host.frame(0, b, t, k);
        check("aborted", 8'h00, {hold, busy});
        seen = 1'b0;
        repeat (50) @(negedge sys_clk) seen |= res_valid;
        check("no_word", 8'h00, seen);
        i_host.release_sel();
        repeat (10) @(negedge sys_clk);
        t_convert(8, 8'hC3, 1'b0, 1'b0, 8'h5A, 8'hC3, 1'b1);
    endtask

    // Fill the FIFO, stall the next conversion, then drain in order
    task automatic t_fifo();
        int len;
        logic [7:0] prev;
        prev = 8'hC3;
        for (int i = 1; i <= 4; i++) begin
            t_convert(8, 8'(i * 8'h11), 1'b0, 1'b0, prev, 8'h00, 1'b0);
            prev = 8'(i * 8'h11);
        end
        run_frame(8, 8'h55, 1'b0, 1'b0, 8'h44, 60, len);
        check("stall", 8'h3C, len[7:0]);
        for (int i = 1; i <= 5; i++) get_word(8'(i * 8'h11));
        i_host.release_sel();
        repeat (40) @(negedge sys_clk);
        check("empty", 8'h00, res_valid);
    endtask

    // Main sequence
    initial begin
        resetn = 1'b0;
        code = 8'h00;
        over = 1'b0;
        under = 1'b0;
        res_ready = 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        t_idle();
        t_convert(8, 8'hA5, 1'b0, 1'b0, 8'h00, 8'hA5, 1'b1);
        t_convert(8, 8'h3C, 1'b1, 1'b0, 8'hA5, 8'hFF, 1'b1);
        t_convert(8, 8'h3C, 1'b0, 1'b1, 8'hFF, 8'h00, 1'b1);
        t_convert(10, 8'h5A, 1'b0, 1'b0, 8'h00, 8'h5A, 1'b1);
        t_abort();
        t_fifo();
        summarize();
    end

    // Hang guard, well beyond the expected run of about 140 us
    initial begin
        #2_000_000;
        failures++;
        summarize();
    end
endmodule // serial_adc_readout_control_tb_top
